// ===== urs_pkg.sv
// Package for the unstructured reassembly service-event register bank
package urs_pkg;

  // Register offsets on the 16-bit microprocessor port
  localparam logic [15:0] URS_SERVICE_ENABLE_OFF = 16'h2002;
  localparam logic [15:0] URS_SERVICE_STATUS_OFF = 16'h2004;
  localparam logic [15:0] URS_CELL_COUNT_OFF     = 16'h2006;

  // Reset values
  localparam logic [15:0] URS_SERVICE_ENABLE_RST = 16'h0000;
  localparam logic [15:0] URS_SERVICE_STATUS_RST = 16'h001f;
  localparam logic [15:0] URS_CELL_COUNT_RST     = 16'h0000;

  // Enable register: one enable bit per rollover type, bits 7:0
  localparam int          URS_EVT_TYPES          = 8;
  localparam logic [7:0]  URS_ENABLE_MASK        = 8'hff;
  localparam int          URS_REASSEMBLED_BIT    = 0;
  localparam int          URS_HEADER_ERR_BIT     = 1;
  localparam int          URS_SEQUENCE_ERR_BIT   = 2;
  localparam int          URS_LOST_CELLS_BIT     = 3;
  localparam int          URS_MISINSERTED_BIT    = 4;
  localparam int          URS_UNDERRUN_BIT       = 5;
  localparam int          URS_OVERRUN_BIT        = 6;
  localparam int          URS_LATE_CELLS_BIT     = 7;

  // Status register fields
  localparam int          URS_PORT_W             = 5;
  localparam int          URS_PORT_LSB           = 0;
  localparam logic [4:0]  URS_PORT_ILLEGAL       = 5'h1f;
  localparam int          URS_TALLY_OVF_SE_BIT   = 12;
  localparam int          URS_TALLY_OVF_BIT      = 13;
  localparam int          URS_SUMMARY_SE_BIT     = 14;
  localparam int          URS_SUMMARY_FLAG_BIT   = 15;

  // Cell counter
  localparam int          URS_CELL_COUNT_W       = 16;
  localparam logic [15:0] URS_CELL_COUNT_MAX     = 16'hffff;
  localparam logic [15:0] URS_CELL_COUNT_ONE     = 16'h0001;

  localparam logic [15:0] URS_ZERO_WORD          = 16'h0000;

endpackage : urs_pkg

// ===== urs_udt_reassembly_event_status.sv
// Service-event register bank of the unstructured reassembly receive path
// Notes on behaviour
// - Enable bit 0 lets a reassembled-cells rollover set the summary flag.
// - Enable bit 1 lets a header-byte error rollover set the summary flag.
// - Enable bit 2 lets a sequence error rollover set the summary flag.
// - Enable bit 3 lets a lost-cells rollover set the summary flag.
// - Enable bit 4 lets a misinserted-cells rollover set the summary flag.
// - Enable bit 5 lets a buffer-underrun rollover set the summary flag.
// - Enable bit 6 lets a buffer-overrun rollover set the summary flag.
// - Enable bit 7 lets a late-cells rollover set the summary flag.
// - Port field holds port of latest unmasked rollover; resets to 1Fh.
// - Summary flag bit 15 sets on any enabled rollover, sticks until cleared.
// - Writing zero to bit 15 clears it and returns port field to 1Fh.
// - Bit 14 set forwards summary flag to main service request.
// - Bit 13 latches when the received-cell counter overflows.
// - Bit 12 set forwards the overflow flag to main service request.
// - Read-only 16-bit cell counter, reset zero, counts each accepted cell.
`timescale 1ns/1ps

module urs_udt_reassembly_event_status
  import urs_pkg::*;
(
  // Clock and reset
  input  wire logic                          CLK_SYS_I,
  input  wire logic                          SRST_I,
  // Microprocessor register port
  input  wire logic [15:0]                   REG_ADDR_I,
  input  wire logic                          REG_WR_I,
  input  wire logic                          REG_RD_I,
  input  wire logic [15:0]                   REG_WDATA_I,
  output logic      [15:0]                   REG_RDATA_O,
  output logic                               REG_RVALID_O,
  // Rollover events from per-port reassembly control structures
  input  wire logic                          ROLL_VALID_I,
  input  wire logic [urs_pkg::URS_EVT_TYPES-1:0] ROLL_TYPE_I,
  input  wire logic [urs_pkg::URS_PORT_W-1:0]    ROLL_PORT_I,
  // Cell accepted by the unstructured receive path
  input  wire logic                          CELL_ACCEPT_I,
  // Request toward the main status register
  output logic                               MAIN_REASSEMBLY_SERVICE_REQUEST_O
);
  import urs_pkg::*;

  typedef struct packed {
    logic [URS_EVT_TYPES-1:0]    rollover_enable;
    logic [URS_PORT_W-1:0]       service_port;
    logic                        cell_tally_overflow_enable;
    logic                        cell_tally_overflow_flag;
    logic                        summary_service_enable;
    logic                        summary_event_flag;
    logic [URS_CELL_COUNT_W-1:0] cell_count;
    logic [15:0]                 rdata;
    logic                        rvalid;
    logic                        service_request;
  } urs_state_s;

  urs_state_s st_r;
  urs_state_s st_nxt;

  // Address match, used for the enable and status register writes
  function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] off);
    reg_hit = (addr == off);
  endfunction

  // Status word assembled from its fields; reserved bits stay zero
  function automatic logic [15:0] status_word(input urs_state_s s);
    logic [15:0] w;
    w = URS_ZERO_WORD;
    w[URS_PORT_LSB +: URS_PORT_W] = s.service_port;
    w[URS_TALLY_OVF_SE_BIT]       = s.cell_tally_overflow_enable;
    w[URS_TALLY_OVF_BIT]          = s.cell_tally_overflow_flag;
    w[URS_SUMMARY_SE_BIT]         = s.summary_service_enable;
    w[URS_SUMMARY_FLAG_BIT]       = s.summary_event_flag;
    status_word = w;
  endfunction

  // Per-type decode of an incoming rollover report
  logic [URS_EVT_TYPES-1:0] type_hit;
  logic                     wr_enable;
  logic                     wr_status;
  logic                     rollover_hit;
  logic                     tally_wrap;
  logic                     clear_summary;
  logic                     clear_tally;

  // One rollover type counts only while its own enable bit is set
  function automatic logic type_on(
    input logic [URS_EVT_TYPES-1:0] kinds,
    input logic [URS_EVT_TYPES-1:0] enables,
    input int                       idx
  );
    type_on = kinds[idx] && enables[idx];
  endfunction

  // Latched flag; a set in the same cycle as a clear wins, so no event is lost
  function automatic logic sticky_next(
    input logic cur,
    input logic set_ev,
    input logic clr_ev
  );
    logic v;
    v = cur;
    if (clr_ev)
    begin
      v = 1'b0;
    end
    if (set_ev)
    begin
      v = 1'b1;
    end
    sticky_next = v;
  endfunction

  // Wrap is seen on the accept that steps the counter past its maximum
  function automatic logic overflow_event(
    input logic [URS_CELL_COUNT_W-1:0] cur,
    input logic                        inc
  );
    overflow_event = inc && (cur == URS_CELL_COUNT_MAX);
  endfunction

  // Counter step; the carry is dropped on purpose so the count wraps to zero
  function automatic logic [URS_CELL_COUNT_W-1:0] tally_next(
    input logic [URS_CELL_COUNT_W-1:0] cur,
    input logic                        inc
  );
    logic [URS_CELL_COUNT_W-1:0] v;
    v = cur;
    if (inc)
    begin
      v = URS_CELL_COUNT_W'(cur + URS_CELL_COUNT_ONE);
    end
    tally_next = v;
  endfunction

  // Port field: latest unmasked event wins, a clear alone returns it to 1Fh
  function automatic logic [URS_PORT_W-1:0] port_next(
    input logic [URS_PORT_W-1:0] cur,
    input logic                  hit,
    input logic                  clr,
    input logic [URS_PORT_W-1:0] port
  );
    logic [URS_PORT_W-1:0] v;
    v = cur;
    if (hit)
    begin
      v = port;
    end
    else if (clr)
    begin
      v = URS_PORT_ILLEGAL;
    end
    port_next = v;
  endfunction

  // Enable register update; reserved bits never take a write
  function automatic logic [URS_EVT_TYPES-1:0] enable_next(
    input logic [URS_EVT_TYPES-1:0] cur,
    input logic                     wr,
    input logic [15:0]              data
  );
    logic [URS_EVT_TYPES-1:0] v;
    v = cur;
    if (wr)
    begin
      v = data[URS_EVT_TYPES-1:0] & URS_ENABLE_MASK;
    end
    enable_next = v;
  endfunction

  // Plain read/write enable bit inside the status word
  function automatic logic enable_bit_next(
    input logic        cur,
    input logic        wr,
    input logic [15:0] data,
    input int          pos
  );
    logic v;
    v = cur;
    if (wr)
    begin
      v = data[pos];
    end
    enable_bit_next = v;
  endfunction

  // Service request from a flag and its enable
  function automatic logic request_of(
    input logic flag,
    input logic enable
  );
    request_of = flag && enable;
  endfunction

  // Enable word with reserved bits forced to zero
  function automatic logic [15:0] enable_word(input logic [URS_EVT_TYPES-1:0] en);
    logic [15:0] w;
    w = URS_ZERO_WORD;
    w[URS_EVT_TYPES-1:0] = en;
    enable_word = w;
  endfunction

  // Read multiplexer; unmapped offsets return zero
  function automatic logic [15:0] read_mux(
    input logic [15:0] addr,
    input urs_state_s  s
  );
    logic [15:0] w;
    w = URS_ZERO_WORD;
    case (addr)
      URS_SERVICE_ENABLE_OFF:
      begin
        w = enable_word(s.rollover_enable);
      end
      URS_SERVICE_STATUS_OFF:
      begin
        w = status_word(s);
      end
      URS_CELL_COUNT_OFF:
      begin
        w = s.cell_count;
      end
      default:
      begin
        w = URS_ZERO_WORD;
      end
    endcase
    read_mux = w;
  endfunction

  // State after reset, built from the package reset words
  function automatic urs_state_s reset_state();
    urs_state_s s;
    s.rollover_enable            = URS_SERVICE_ENABLE_RST[URS_EVT_TYPES-1:0];
    s.service_port               = URS_SERVICE_STATUS_RST[URS_PORT_W-1:0];
    s.cell_tally_overflow_enable = URS_SERVICE_STATUS_RST[URS_TALLY_OVF_SE_BIT];
    s.cell_tally_overflow_flag   = URS_SERVICE_STATUS_RST[URS_TALLY_OVF_BIT];
    s.summary_service_enable     = URS_SERVICE_STATUS_RST[URS_SUMMARY_SE_BIT];
    s.summary_event_flag         = URS_SERVICE_STATUS_RST[URS_SUMMARY_FLAG_BIT];
    s.cell_count                 = URS_CELL_COUNT_RST;
    s.rdata                      = URS_ZERO_WORD;
    s.rvalid                     = 1'b0;
    s.service_request            = 1'b0;
    reset_state = s;
  endfunction

  always_comb
  begin
    type_hit = '0;

    if (type_on(ROLL_TYPE_I, st_r.rollover_enable, URS_REASSEMBLED_BIT))
    begin
      type_hit[URS_REASSEMBLED_BIT] = 1'b1;
    end

    if (type_on(ROLL_TYPE_I, st_r.rollover_enable, URS_HEADER_ERR_BIT))
    begin
      type_hit[URS_HEADER_ERR_BIT] = 1'b1;
    end

    if (type_on(ROLL_TYPE_I, st_r.rollover_enable, URS_SEQUENCE_ERR_BIT))
    begin
      type_hit[URS_SEQUENCE_ERR_BIT] = 1'b1;
    end

    if (type_on(ROLL_TYPE_I, st_r.rollover_enable, URS_LOST_CELLS_BIT))
    begin
      type_hit[URS_LOST_CELLS_BIT] = 1'b1;
    end

    if (type_on(ROLL_TYPE_I, st_r.rollover_enable, URS_MISINSERTED_BIT))
    begin
      type_hit[URS_MISINSERTED_BIT] = 1'b1;
    end

    if (type_on(ROLL_TYPE_I, st_r.rollover_enable, URS_UNDERRUN_BIT))
    begin
      type_hit[URS_UNDERRUN_BIT] = 1'b1;
    end

    if (type_on(ROLL_TYPE_I, st_r.rollover_enable, URS_OVERRUN_BIT))
    begin
      type_hit[URS_OVERRUN_BIT] = 1'b1;
    end

    if (type_on(ROLL_TYPE_I, st_r.rollover_enable, URS_LATE_CELLS_BIT))
    begin
      type_hit[URS_LATE_CELLS_BIT] = 1'b1;
    end
  end

  always_comb
  begin
    st_nxt = st_r;

    wr_enable = REG_WR_I && reg_hit(REG_ADDR_I, URS_SERVICE_ENABLE_OFF);
    wr_status = REG_WR_I && reg_hit(REG_ADDR_I, URS_SERVICE_STATUS_OFF);

    rollover_hit  = ROLL_VALID_I && (type_hit != '0);
    tally_wrap    = overflow_event(st_r.cell_count, CELL_ACCEPT_I);
    clear_summary = wr_status && !REG_WDATA_I[URS_SUMMARY_FLAG_BIT];
    clear_tally   = wr_status && !REG_WDATA_I[URS_TALLY_OVF_BIT];

    st_nxt.rollover_enable =
      enable_next(st_r.rollover_enable, wr_enable, REG_WDATA_I);

    st_nxt.cell_tally_overflow_enable =
      enable_bit_next(st_r.cell_tally_overflow_enable, wr_status, REG_WDATA_I,
                      URS_TALLY_OVF_SE_BIT);
    st_nxt.summary_service_enable =
      enable_bit_next(st_r.summary_service_enable, wr_status, REG_WDATA_I,
                      URS_SUMMARY_SE_BIT);

    st_nxt.summary_event_flag =
      sticky_next(st_r.summary_event_flag, rollover_hit, clear_summary);
    st_nxt.cell_tally_overflow_flag =
      sticky_next(st_r.cell_tally_overflow_flag, tally_wrap, clear_tally);
    st_nxt.service_port =
      port_next(st_r.service_port, rollover_hit, clear_summary, ROLL_PORT_I);

    st_nxt.cell_count = tally_next(st_r.cell_count, CELL_ACCEPT_I);

    // Read data is registered, so a read beside a write returns the old value
    st_nxt.rvalid = REG_RD_I;
    st_nxt.rdata  = URS_ZERO_WORD;
    if (REG_RD_I)
    begin
      st_nxt.rdata = read_mux(REG_ADDR_I, st_r);
    end

    // Request follows the flags as they will stand after this edge
    st_nxt.service_request =
      request_of(st_nxt.summary_event_flag, st_nxt.summary_service_enable) ||
      request_of(st_nxt.cell_tally_overflow_flag, st_nxt.cell_tally_overflow_enable);
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
    begin
      st_r <= reset_state();
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign REG_RDATA_O                       = st_r.rdata;
  assign REG_RVALID_O                      = st_r.rvalid;
  assign MAIN_REASSEMBLY_SERVICE_REQUEST_O = st_r.service_request;

endmodule // urs_udt_reassembly_event_status

// ===== urs_event_status_properties.sv
// Port-level assertions of the reassembly service-event bank
`timescale 1ns/1ps
module urs_props
  import urs_pkg::*;
(
  input logic CLK_SYS_I, input logic SRST_I,
  input logic [15:0] REG_ADDR_I, input logic REG_WR_I, input logic REG_RD_I,
  input logic [15:0] REG_WDATA_I, input logic [15:0] REG_RDATA_O, input logic REG_RVALID_O,
  input logic ROLL_VALID_I, input logic [7:0] ROLL_TYPE_I, input logic [4:0] ROLL_PORT_I,
  input logic CELL_ACCEPT_I, input logic MAIN_REASSEMBLY_SERVICE_REQUEST_O
);
  // Shadows of the cell count and written enables; edges with a write are left out since writes may clear
  logic [15:0] cnt_r;
  logic [7:0]  en_r;
  logic [1:0]  se_r;
  wire         wr_st = REG_WR_I && REG_ADDR_I == URS_SERVICE_STATUS_OFF;
  wire         wr_en = REG_WR_I && REG_ADDR_I == URS_SERVICE_ENABLE_OFF;
  wire         hit = ROLL_VALID_I && |(ROLL_TYPE_I & en_r);
  wire         req = MAIN_REASSEMBLY_SERVICE_REQUEST_O;
  always_ff @(posedge CLK_SYS_I)
  begin
    cnt_r <= SRST_I ? 16'h0000 : cnt_r + 16'(CELL_ACCEPT_I);
    en_r  <= SRST_I ? 8'h00 : wr_en ? REG_WDATA_I[7:0] : en_r;
    se_r  <= SRST_I ? 2'h0 : wr_st ? {REG_WDATA_I[14], REG_WDATA_I[12]} : se_r;
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);
  AST_RD_ANSWER: assert property (REG_RD_I |=> REG_RVALID_O) else $error("no answer");
  AST_RV_CAUSE: assert property (REG_RVALID_O |-> $past(REG_RD_I)) else $error("stray");
  AST_IDLE_ZERO: assert property (!REG_RVALID_O |-> !REG_RDATA_O) else $error("idle data");
  AST_CNT_READ: assert property (REG_RD_I && REG_ADDR_I == URS_CELL_COUNT_OFF
    |=> REG_RDATA_O == $past(cnt_r)) else $error("bad count");
  AST_SUM_REQ: assert property (hit && se_r[1] && !REG_WR_I |=> req)
    else $error("no summary request");
  AST_OVF_REQ: assert property (CELL_ACCEPT_I && &cnt_r && se_r[0] && !REG_WR_I
    |=> req) else $error("no overflow request");
  AST_CLEAR: assert property (wr_st && !REG_WDATA_I[15] && !REG_WDATA_I[13]
    && !ROLL_VALID_I && !CELL_ACCEPT_I |=> !req) else $error("clear ignored");
  AST_STICKY: assert property (req && !REG_WR_I |=> req) else $error("request dropped");
  cover property (hit && se_r[1]);
  cover property (CELL_ACCEPT_I && &cnt_r);
  cover property (wr_st && !REG_WDATA_I[15]);
endmodule // urs_props
bind urs_udt_reassembly_event_status urs_props i_props (.CLK_SYS_I, .SRST_I, .REG_ADDR_I,
  .REG_WR_I, .REG_RD_I, .REG_WDATA_I, .REG_RDATA_O, .REG_RVALID_O, .ROLL_VALID_I,
  .ROLL_TYPE_I, .ROLL_PORT_I, .CELL_ACCEPT_I, .MAIN_REASSEMBLY_SERVICE_REQUEST_O);

// ===== urs_udt_reassembly_event_status_tb.sv
// Directed register-sequence bench of the reassembly service-event bank
`timescale 1ns/1ps
module urs_udt_reassembly_event_status_tb;
  import urs_pkg::*;
  localparam logic [2:0] wr_op = 3'b100, rd_op = 3'b010, ev_op = 3'b001;
  logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, rv = 1'b0, acc = 1'b0;
  logic        rvalid, req;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
  int          miscompares = 0, comparisons = 0;
  always #2 clk = ~clk;
  // Event type and port ride on the data and address lines, so one task drives reads, writes and events
  urs_udt_reassembly_event_status i_dut (.CLK_SYS_I(clk), .SRST_I(srst), .REG_ADDR_I(addr),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .ROLL_VALID_I(rv), .ROLL_TYPE_I(wdata[7:0]),
    .ROLL_PORT_I(addr[4:0]), .CELL_ACCEPT_I(acc), .MAIN_REASSEMBLY_SERVICE_REQUEST_O(req));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    miscompares += int'(seen !== exp);
    if (seen !== exp)
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
  endtask
  task automatic drv(input logic [2:0] op, input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    {wr, rd, rv, addr, wdata} = {op, a, d};
    @(negedge clk);
    {wr, rd, rv} = 3'b000;
    if (op[1])
      chk(rdata, d);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // The full counter wrap dominates the run, about 66k cycles
  initial
  begin
    repeat (90000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
  initial
  begin
    repeat (6) @(negedge clk);
    srst = 1'b0;
    drv(rd_op, URS_SERVICE_ENABLE_OFF, 16'h0000);
    drv(rd_op, URS_SERVICE_STATUS_OFF, 16'h001f);
    drv(rd_op, URS_CELL_COUNT_OFF, 16'h0000);
    drv(rd_op, 16'h2008, 16'h0000);
    drv(wr_op, URS_SERVICE_ENABLE_OFF, 16'hffff);
    drv(rd_op, URS_SERVICE_ENABLE_OFF, 16'h00ff);
    drv(wr_op, URS_SERVICE_STATUS_OFF, 16'hffff);
    drv(rd_op, URS_SERVICE_STATUS_OFF, 16'h501f);
    for (int n = 0; n < 8; n++)
    begin
      drv(wr_op, URS_SERVICE_ENABLE_OFF, 16'h0001 << n);
      drv(ev_op, 16'(n + 9), 16'h0001 << n);
      drv(ev_op, 16'h0005, 16'h00ff ^ (16'h0001 << n));
      drv(rd_op, URS_SERVICE_STATUS_OFF, 16'hd000 | 16'(n + 9));
      drv(wr_op, URS_SERVICE_STATUS_OFF, 16'h5000);
    end
    drv(wr_op, URS_CELL_COUNT_OFF, 16'h1234);
    acc = 1'b1;
    repeat (65536) @(negedge clk);
    acc = 1'b0;
    drv(rd_op, URS_CELL_COUNT_OFF, 16'h0000);
    drv(rd_op, URS_SERVICE_STATUS_OFF, 16'h701f);
    chk(16'(req), 16'h0001);
    drv(wr_op, URS_SERVICE_STATUS_OFF, 16'h4000);
    drv(rd_op, URS_SERVICE_STATUS_OFF, 16'h401f);
    end_of_test();
  end
endmodule // urs_udt_reassembly_event_status_tb
